//--- shared/sleep_pkg.sv
// package for the sleep mode controller: mode codes, states, carriers and timing
package sleep_pkg;

  // sleep mode selection codes (three-bit field)
  localparam logic [2:0] IDLE_CODE              = 3'h0;
  localparam logic [2:0] POWER_DOWN_CODE        = 3'h2;
  localparam logic [2:0] POWER_SAVE_CODE        = 3'h3;
  localparam logic [2:0] STANDBY_CODE           = 3'h6;
  localparam logic [2:0] EXTENDED_STANDBY_CODE  = 3'h7;

  // cycles the cpu stays halted after any wake-up
  localparam int unsigned WAKE_HALT_CYCLES = 4;
  localparam logic [2:0]  WAKE_HALT_LAST   = 3'(WAKE_HALT_CYCLES - 1);
  localparam logic [2:0]  HALT_CNT_ZERO    = 3'h0;

  // default clock source start-up wait, in system clock cycles
  localparam int unsigned OSC_START_CYCLES_DEFAULT = 64;

  // sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_ACTIVE = 5'h01,
    ST_SLEEP  = 5'h02,
    ST_START  = 5'h04,
    ST_HALT   = 5'h08,
    ST_WAKE   = 5'h10
  } seq_state_t;

  // wake-up sources offered by the surrounding logic
  typedef struct packed {
    logic port_async;   // asynchronous port pin interrupt
    logic twi_match;    // two-wire address match interrupt
    logic rtc_irq;      // real-time counter overflow or compare
    logic any_irq;      // any enabled interrupt
  } wake_src_t;

  // clock and oscillator gates driven out, high means running
  typedef struct packed {
    logic cpu_clk;
    logic nvm_clk;
    logic per_clk;
    logic rtc_clk;
    logic sys_osc;
    logic rtc_osc;
  } clk_gate_t;

endpackage : sleep_pkg

//--- design/sleep_mode_controller.sv
// sleep and power-mode sequencer: clock gating, wake-up selection and wake halt
`timescale 1ns/10ps

// sequence of one sleep: the core issues the sleep instruction while armed
// with a defined mode code. the mode is latched, and the clock gates take
// that mode's pattern one cycle later. a wake source that the latched mode
// allows, seen through two synchroniser flops, ends the sleep. modes that stop
// the system clock source first wait out its start-up. every wake then holds
// the core for four cycles with all other clocks running by the second of them, and one
// resume cycle hands control to the interrupt controller.
// limitation: priority among pending interrupts belongs to the interrupt
// controller; this block only tells it when the core may run again.
// trade-off: status outputs are registered, so they lag the state by a cycle.

// Overview of operation
// - sleep instruction enters selected mode from active
// - enabled wake interrupt serviced, then resume after sleep
// - pending higher priority interrupts served first
// - cpu halted four cycles after every wake
// - idle stops cpu, nvm when not busy; peripherals keep running
// - power-down stops every clock and oscillator
// - power-down wakes on twi match, port pins
// - power-save keeps rtc running, rtc wakes
// - standby keeps system clock source running
// - extended standby is power-save plus system source
// - register file, sram, registers kept while sleeping
// - reset during sleep restarts at reset vector
// - stopped system source adds start-up wait
// - resets and mode wake sources end sleep
// - software gates individual peripheral clocks
// - mode codes 000 010 011 110 111
// - sleep only while arm bit set
module sleep_mode_controller
  import sleep_pkg::*;
#(
  parameter int unsigned NUM_PERIPH        = 8,
  parameter int unsigned OSC_START_CYCLES  = OSC_START_CYCLES_DEFAULT,
  parameter int unsigned START_CNT_W       = 16
) (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_reset,
  // cpu side
  input  wire logic                  i_sleep_instr,
  input  wire logic [2:0]            i_sleep_mode_select,
  input  wire logic                  i_sleep_arm_bit,
  input  wire logic                  i_nvm_busy,
  input  wire logic                  i_rtc_enabled,
  input  wire logic [NUM_PERIPH-1:0] i_periph_stop,
  // wake sources, levels from outside the domain
  input  wire wake_src_t             i_wake_src,
  // clock generator and cpu control
  output      clk_gate_t             o_clk_gate,
  output      logic [NUM_PERIPH-1:0] o_periph_clk_en,
  output      logic                  o_cpu_halt,
  output      logic                  o_sleeping,
  output      logic                  o_wake_pulse,
  output      logic [2:0]            o_active_mode
);

  // true for the five defined codes
  function automatic logic mode_valid(input logic [2:0] m);
    case (m)
      IDLE_CODE, POWER_DOWN_CODE, POWER_SAVE_CODE, STANDBY_CODE, EXTENDED_STANDBY_CODE: mode_valid = 1'b1;
      default: mode_valid = 1'b0;
    endcase
  endfunction : mode_valid

  // gate pattern held during each mode
  function automatic clk_gate_t mode_gates(input logic [2:0] m, input logic rtc_en, input logic nvm_busy);
    clk_gate_t g;
    g = '0;
    case (m)
      IDLE_CODE: begin
        g.nvm_clk = nvm_busy;
        g.per_clk = 1'b1;
        g.rtc_clk = 1'b1;
        g.sys_osc = 1'b1;
        g.rtc_osc = 1'b1;
      end
      POWER_DOWN_CODE: g = '0;
      POWER_SAVE_CODE: begin
        g.rtc_clk = rtc_en;
        g.rtc_osc = rtc_en;
      end
      STANDBY_CODE: g.sys_osc = 1'b1;
      EXTENDED_STANDBY_CODE: begin
        g.sys_osc = 1'b1;
        g.rtc_clk = rtc_en;
        g.rtc_osc = rtc_en;
      end
      default: g = '0;
    endcase
    mode_gates = g;
  endfunction : mode_gates

  // wake decision per mode
  function automatic logic mode_wakes(input logic [2:0] m, input wake_src_t w, input logic rtc_en);
    case (m)
      IDLE_CODE:             mode_wakes = w.any_irq | w.port_async | w.twi_match | w.rtc_irq;
      POWER_DOWN_CODE,
      STANDBY_CODE:          mode_wakes = w.port_async | w.twi_match;
      POWER_SAVE_CODE,
      EXTENDED_STANDBY_CODE: mode_wakes = w.port_async | w.twi_match | (rtc_en & w.rtc_irq);
      default:               mode_wakes = 1'b0;
    endcase
  endfunction : mode_wakes

  seq_state_t             state_reg;
  logic [2:0]             mode_reg;
  logic [2:0]             halt_cnt_reg;
  logic [START_CNT_W-1:0] start_cnt_reg;
  wake_src_t              wake_meta_reg;
  wake_src_t              wake_sync_reg;
  logic                   wake_hit;
  logic                   sleep_ok;
  logic                   osc_was_off;
  logic                   start_done;
  clk_gate_t              sleep_gates;
  logic                   halt_last;
  logic                   periph_all_off;
  // status next values
  logic                   cpu_halt_next;
  logic                   sleeping_next;
  logic                   wake_pulse_next;

  // two-flop synchronisers on the wake levels; async sources stay meaningful in any mode
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wake_meta_reg <= '0;
      wake_sync_reg <= '0;
    end else begin
      wake_meta_reg <= i_wake_src;
      wake_sync_reg <= wake_meta_reg;
    end
  end

  assign sleep_ok    = i_sleep_instr & i_sleep_arm_bit & mode_valid(i_sleep_mode_select);
  assign wake_hit    = mode_wakes(mode_reg, wake_sync_reg, i_rtc_enabled);
  // gate pattern of the latched mode; its oscillator bit also picks the wake path
  assign sleep_gates    = mode_gates(mode_reg, i_rtc_enabled, i_nvm_busy);
  assign osc_was_off    = ~sleep_gates.sys_osc;
  // last of the halt cycles, shared by the resume pulse and the halt release
  assign halt_last      = (halt_cnt_reg == WAKE_HALT_LAST);
  // deep modes stop the whole peripheral clock; single stops apply in active, idle and the wake path
  assign periph_all_off = (state_reg == ST_SLEEP) && (mode_reg != IDLE_CODE);
  assign start_done  = (start_cnt_reg == START_CNT_W'(OSC_START_CYCLES - 1));

  // main sequencer; reset from any state returns to active, the cpu then fetches the reset vector
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_reg <= ST_ACTIVE;
    end else begin
      case (state_reg)
        ST_ACTIVE: begin
          if (sleep_ok) begin
            state_reg <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (wake_hit) begin
            state_reg <= osc_was_off ? ST_START : ST_HALT;
          end
        end
        ST_START: begin
          if (start_done) begin
            state_reg <= ST_HALT;
          end
        end
        ST_HALT: begin
          if (halt_cnt_reg == WAKE_HALT_LAST) begin
            state_reg <= ST_WAKE;
          end
        end
        ST_WAKE: state_reg <= ST_ACTIVE;
        default: state_reg <= ST_ACTIVE;
      endcase
    end
  end

  // mode captured at sleep entry so a later select change cannot alter a sleep in progress
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      mode_reg <= IDLE_CODE;
    end else if (state_reg == ST_ACTIVE && sleep_ok) begin
      mode_reg <= i_sleep_mode_select;
    end
  end

  // oscillator start-up counter
  always_ff @(posedge i_clk) begin
    if (i_reset || state_reg != ST_START) begin
      start_cnt_reg <= '0;
    end else if (!start_done) begin
      start_cnt_reg <= start_cnt_reg + START_CNT_W'(1);
    end
  end

  // wake halt counter
  always_ff @(posedge i_clk) begin
    if (i_reset || state_reg != ST_HALT) begin
      halt_cnt_reg <= HALT_CNT_ZERO;
    end else begin
      halt_cnt_reg <= halt_cnt_reg + 3'h1;
    end
  end

  // gate outputs: registered so no glitch reaches the clock gates
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_clk_gate <= '1;
    end else begin
      case (state_reg)
        ST_SLEEP: o_clk_gate <= mode_gates(mode_reg, i_rtc_enabled, i_nvm_busy);
        ST_START, ST_HALT: begin
          // clocks restart while the cpu stays halted; state is only frozen, never cleared
          o_clk_gate         <= '1;
          o_clk_gate.cpu_clk <= 1'b0;
        end
        default: o_clk_gate <= '1;
      endcase
    end
  end

  // per-peripheral clock stop honoured in active, idle and the wake path, deeper modes gate everything
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_periph_clk_en <= '1;
    end else if (periph_all_off) begin
      o_periph_clk_en <= '0;
    end else begin
      o_periph_clk_en <= ~i_periph_stop;
    end
  end

  // cpu status next values, worked out per state so each state shows its intent
  always_comb begin
    cpu_halt_next   = 1'b0;
    sleeping_next   = 1'b0;
    wake_pulse_next = 1'b0;
    case (state_reg)
      ST_ACTIVE: begin
        // the entry cycle already reports halted so the core issues nothing more
        cpu_halt_next = sleep_ok;
        sleeping_next = sleep_ok;
      end
      ST_SLEEP: begin
        cpu_halt_next = 1'b1;
        sleeping_next = 1'b1;
      end
      ST_START: begin
        cpu_halt_next = 1'b1;
      end
      ST_HALT: begin
        // halt drops in the very cycle the resume pulse rises, so the core loses no extra cycle
        cpu_halt_next   = ~halt_last;
        wake_pulse_next = halt_last;
      end
      default: begin
        cpu_halt_next   = 1'b0;
        sleeping_next   = 1'b0;
        wake_pulse_next = 1'b0;
      end
    endcase
  end

  // cpu halt towards the core
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_cpu_halt <= 1'b0;
    end else begin
      o_cpu_halt <= cpu_halt_next;
    end
  end

  // sleep status, high from the entry cycle until the wake path starts
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_sleeping <= 1'b0;
    end else begin
      o_sleeping <= sleeping_next;
    end
  end

  // resume pulse; the interrupt controller then vectors by its own priority
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_wake_pulse <= 1'b0;
    end else begin
      o_wake_pulse <= wake_pulse_next;
    end
  end

  // mode report, lags the latched mode by one cycle
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_active_mode <= IDLE_CODE;
    end else begin
      o_active_mode <= mode_reg;
    end
  end

endmodule : sleep_mode_controller

//--- testbench/sleep_mode_controller_props.sv
// port checker for the sleep mode controller
`timescale 1ns/10ps
module sleep_mode_controller_props
  import sleep_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_reset,
  input wire logic       i_sleep_instr,
  input wire logic [2:0] i_sleep_mode_select,
  input wire logic       i_sleep_arm_bit,
  input wire clk_gate_t  o_clk_gate,
  input wire logic       o_cpu_halt,
  input wire logic       o_sleeping,
  input wire logic       o_wake_pulse
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // an instruction counts only while fully awake
  logic awake;
  logic rsv;
  assign awake = i_sleep_instr && !o_sleeping && !o_cpu_halt && !o_wake_pulse;
  assign rsv   = i_sleep_mode_select inside {3'h1, 3'h4, 3'h5};
  sequence s_enter(code);
    awake && i_sleep_arm_bit && i_sleep_mode_select == code ##1 o_sleeping;
  endsequence
  property p_gate(code, mask, pat);
    s_enter(code) |=> (o_clk_gate & mask) == pat;
  endproperty
  property p_enter;
    awake && i_sleep_arm_bit && !rsv |=> o_sleeping && o_cpu_halt;
  endproperty
  property p_noop;
    awake && (!i_sleep_arm_bit || rsv) |=> !o_sleeping && !o_cpu_halt;
  endproperty
  property p_pulse;
    o_wake_pulse |=> !o_wake_pulse;
  endproperty
  // halt must be high one, four and five cycles before the pulse and low with it
  property p_halt;
    o_wake_pulse |-> !o_cpu_halt && $past(o_cpu_halt, 1) && $past(o_cpu_halt, 4) && $past(o_cpu_halt, 5);
  endproperty
  // with the pulse and three cycles before it every clock but the cpu's runs again, nothing was reset
  property p_restart;
    o_wake_pulse |-> o_clk_gate == 6'h1F && $past(o_clk_gate, 3) == 6'h1F;
  endproperty
  a_enter: assert property (p_enter) else $error("sleep entry missed");
  a_noop: assert property (p_noop) else $error("refused sleep taken");
  a_pulse: assert property (p_pulse) else $error("wake pulse too long");
  a_halt: assert property (p_halt) else $error("wake halt too short");
  a_restart: assert property (p_restart) else $error("halt gates wrong");
  a_gate_idle: assert property (p_gate(IDLE_CODE, 6'h28, 6'h08)) else $error("idle gates");
  a_gate_power_down_code: assert property (p_gate(POWER_DOWN_CODE, 6'h3F, 6'h00)) else $error("power_down_code gates");
  a_gate_power_save_code: assert property (p_gate(POWER_SAVE_CODE, 6'h3A, 6'h00)) else $error("power_save_code gates");
  a_gate_stby: assert property (p_gate(STANDBY_CODE, 6'h3F, 6'h02)) else $error("standby gates");
  a_gate_ext: assert property (p_gate(EXTENDED_STANDBY_CODE, 6'h3A, 6'h02)) else $error("ext gates");
endmodule : sleep_mode_controller_props

//--- testbench/sleep_cpu_model.sv
// cpu and interrupt controller stand-in: holds wake requests until served
`timescale 1ns/10ps
module sleep_cpu_model
  import sleep_pkg::*;
(
  input  wire logic      i_clk,
  input  wire logic      i_reset,
  input  wire wake_src_t i_raise,
  input  wire logic      i_wake_pulse,
  output wake_src_t      o_wake_src
);
  // a request stays pending until its service starts, ignored ones linger
  always_ff @(posedge i_clk) begin
    if (i_reset || i_wake_pulse) begin
      o_wake_src <= '0;
    end else begin
      o_wake_src <= o_wake_src | i_raise;
    end
  end
endmodule : sleep_cpu_model

//--- testbench/sleep_mode_controller_test.sv
// self-checking bench for the sleep mode controller
`timescale 1ns/10ps
module sleep_mode_controller_test
  import sleep_pkg::*;
;
  localparam int unsigned OSC = 2; // short start-up keeps the run brief
  logic       i_clk = 1'b0;
  logic       i_reset = 1'b1;
  logic       i_sleep_instr = 1'b0;
  logic [2:0] i_sleep_mode_select = 3'h0;
  logic       i_sleep_arm_bit = 1'b0;
  logic       i_nvm_busy = 1'b0;
  logic       i_rtc_enabled = 1'b0;
  logic [7:0] i_periph_stop = 8'h00;
  wake_src_t  wake_req = '0;
  wake_src_t  i_wake_src;
  clk_gate_t  o_clk_gate;
  logic [7:0] o_periph_clk_en;
  logic       o_cpu_halt, o_sleeping, o_wake_pulse;
  logic [2:0] o_active_mode;
  int         n_mismatch = 0, samples_checked = 0, cycles = 0;
  sleep_mode_controller #(.OSC_START_CYCLES(OSC)) i_sleep_mode_controller (.i_clk, .i_reset, .i_sleep_instr,
    .i_sleep_mode_select, .i_sleep_arm_bit, .i_nvm_busy, .i_rtc_enabled, .i_periph_stop, .i_wake_src, .o_clk_gate,
    .o_periph_clk_en, .o_cpu_halt, .o_sleeping, .o_wake_pulse, .o_active_mode);
  sleep_cpu_model i_sleep_cpu_model (.i_clk, .i_reset, .i_raise(wake_req), .i_wake_pulse(o_wake_pulse),
    .o_wake_src(i_wake_src));
  always #10 i_clk = ~i_clk;
  // hang guard, the whole run needs well under a thousand cycles
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    $display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  // one sleep instruction, taken at the second edge
  task automatic go(input logic [2:0] code, input logic arm);
    @(posedge i_clk);
    i_sleep_mode_select <= code;
    i_sleep_arm_bit <= arm;
    i_sleep_instr <= 1'b1;
    wake_req <= '0;
    @(posedge i_clk);
    i_sleep_instr <= 1'b0;
    #1;
  endtask : go
  // raise a source and count edges until the core resumes
  task automatic wake(input logic [3:0] src, input int unsigned exp);
    int unsigned n;
    n = 0;
    @(posedge i_clk);
    wake_req <= src;
    @(posedge i_clk);
    wake_req <= '0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
    end while (!o_wake_pulse && n < 40);
    chk(16'(n), 16'(exp));
    @(posedge i_clk);
    i_sleep_arm_bit <= 1'b0;
  endtask : wake
  task automatic t_modes;
    logic [2:0] codes[5] = '{IDLE_CODE, POWER_DOWN_CODE, POWER_SAVE_CODE, STANDBY_CODE, EXTENDED_STANDBY_CODE};
    int unsigned lat[5] = '{7, 7 + OSC, 7 + OSC, 7, 7};
    for (int k = 0; k < 5; k++) begin
      go(codes[k], 1'b1);
      @(posedge i_clk);
      #1;
      chk({o_sleeping, o_cpu_halt, o_active_mode}, {2'h3, codes[k]});
      wake(4'h4, lat[k]);
    end
  endtask : t_modes
  task automatic t_refuse;
    logic [2:0] bad[4] = '{IDLE_CODE, 3'h1, 3'h4, 3'h5};
    for (int k = 0; k < 4; k++) begin
      go(bad[k], k != 0);
      chk({o_sleeping, o_cpu_halt}, 2'h0);
    end
  endtask : t_refuse
  // power-down must ignore rtc, general interrupts and a second instruction
  task automatic t_deep;
    @(posedge i_clk);
    i_rtc_enabled <= 1'b1;
    go(POWER_DOWN_CODE, 1'b1);
    @(posedge i_clk);
    wake_req <= 4'h3;
    go(IDLE_CODE, 1'b1);
    repeat (20) @(posedge i_clk);
    #1;
    chk({o_sleeping, o_active_mode, o_clk_gate}, {1'b1, POWER_DOWN_CODE, 6'h00});
    chk(o_periph_clk_en, 8'h00);
    wake(4'h8, 7 + OSC);
  endtask : t_deep
  task automatic t_rtc;
    go(POWER_SAVE_CODE, 1'b1);
    @(posedge i_clk);
    #1;
    chk(o_clk_gate.rtc_clk, 1'b1);
    wake(4'h2, 7 + OSC);
    go(EXTENDED_STANDBY_CODE, 1'b1);
    wake(4'h2, 7);
  endtask : t_rtc
  task automatic t_idle;
    @(posedge i_clk);
    i_periph_stop <= 8'hA5;
    i_nvm_busy <= 1'b1;
    go(IDLE_CODE, 1'b1);
    @(posedge i_clk);
    #1;
    chk({o_periph_clk_en, o_clk_gate}, {8'h5A, 6'h1F});
    wake(4'h1, 7);
  endtask : t_idle
  task automatic t_reset;
    go(STANDBY_CODE, 1'b1);
    @(posedge i_clk);
    i_reset <= 1'b1;
    @(posedge i_clk);
    i_reset <= 1'b0;
    #1;
    chk({o_sleeping, o_cpu_halt, o_active_mode, o_clk_gate}, {2'h0, 3'h0, 6'h3F});
  endtask : t_reset
  initial begin
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    t_modes();
    t_refuse();
    t_deep();
    t_rtc();
    t_idle();
    t_reset();
    results();
  end
endmodule : sleep_mode_controller_test
bind sleep_mode_controller sleep_mode_controller_props i_sleep_mode_controller_props (.i_clk, .i_reset,
  .i_sleep_instr, .i_sleep_mode_select, .i_sleep_arm_bit, .o_clk_gate, .o_cpu_halt, .o_sleeping, .o_wake_pulse);
